// >>> core/sbt_pkg.sv
// package: register map, field positions, reset values and shared types for the serial block
package sbt_pkg;
    localparam logic [7:0] ADDR_DATA    = 8'hF1;
    localparam logic [7:0] ADDR_STATUS  = 8'hF2;
    localparam logic [7:0] ADDR_CONTROL = 8'hF3;
    localparam logic [7:0] ADDR_DIVISOR = 8'hF4;
    localparam logic [7:0] ADDR_IRQCTL  = 8'hF5;

    localparam int ST_RXFULL = 7;
    localparam int ST_PARERR = 6;
    localparam int ST_OVRUN  = 5;
    localparam int ST_FRMERR = 4;
    localparam int ST_BREAK  = 3;
    localparam int ST_TXRDY  = 2;
    localparam int ST_TXDONE = 1;
    localparam int ST_NOISE  = 0;

    localparam int CT_TXEN   = 7;
    localparam int CT_RXEN   = 6;
    localparam int CT_IRQEN  = 5;
    localparam int CT_PAREN  = 4;
    localparam int CT_PARODD = 3;
    localparam int CT_SBRK   = 2;
    localparam int CT_STOP2  = 1;
    localparam int CT_TIMER  = 0;

    localparam logic [7:0] STATUS_RESET  = 8'h02;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DIVISOR_RESET = 8'hFF;
    localparam logic [7:0] IRQCTL_RESET  = 8'h00;

    localparam int PRESCALE_DIV  = 16;
    localparam int PRESCALE_W    = 4;
    localparam int OVERSAMPLE    = 16;

    // wishbone request carried into the slave
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [7:0] dat;
    } sbt_wb_req_t;

    // per-character result from the receive shifter
    typedef struct packed {
        logic       done;
        logic [7:0] data;
        logic       par_err;
        logic       frm_err;
        logic       brk;
        logic       noise;
    } sbt_rx_res_t;
endpackage : sbt_pkg

// >>> core/sbt_baud_gen.sv
// baud generator: prescaler plus 8-bit reloading down-counter
`timescale 1ns/1ps
module sbt_baud_gen #(
    parameter int CNT_W = 8
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [CNT_W-1:0] divisor_i,
    output logic                  tick_o,
    output logic                  reload_o,
    output logic [CNT_W-1:0]      count_o
);
    import sbt_pkg::*;

    logic [PRESCALE_W-1:0] pre_q;
    logic                  pre_tick;
    logic [CNT_W-1:0]      cnt_q;

    // divide system clock by 16
    assign pre_tick = (pre_q == PRESCALE_W'(PRESCALE_DIV - 1)); // R11
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRESCALE_W'(1);
        end
    end

    // down-count; at 1 reload; zero counts 256 steps
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cnt_q    <= CNT_W'(DIVISOR_RESET);
            reload_o <= 1'b0;
        end else begin
            reload_o <= 1'b0;
            if (pre_tick) begin
                if (cnt_q == CNT_W'(1)) begin
                    cnt_q    <= divisor_i; // R14 R12
                    reload_o <= 1'b1; // R10
                end else begin
                    cnt_q <= cnt_q - CNT_W'(1); // R11
                end
            end
        end
    end

    assign tick_o  = reload_o;
    assign count_o = cnt_q;
endmodule : sbt_baud_gen

// >>> core/sbt_uart.sv
// serial transceiver top: wishbone registers, receiver error logic, transmitter, timer
`timescale 1ns/1ps
// Overview of operation
// R1: completed character in holding register raises maskable data interrupt; read clears.
// R2: break is line low for whole character incl. parity and stop bits.
// R3: break interrupts at once if holding empty, else after holding read.
// R4: character arriving onto unread data flags overrun, new byte discarded.
// R5: overrun interrupt asserts at holding read, cleared by next read.
// R6: framing error when first stop bit is 0; only first checked.
// R7: framing interrupt raised when detected, cleared by holding read.
// R8: overrun and break flags hidden until held byte read; receive-full kept.
// R9: software rereads holding after overrun; refill only with next character.
// R10: baud reload raises receiver interrupt when timer interrupt enabled.
// R11: counter clocked at system clock over 16; divisor sets bit rate.
// R12: divisor zero acts as 256, giving clock over 4096.
// R13: timer mode needs enables cleared then timer bit set; counts down.
// R14: at count 1 raise timeout interrupt, reload, keep counting.
// R15: in timer mode divisor location reads live count.
// R16: data location reads received byte, write queues byte to transmit.
// R17: data read clears status bits 7 and 6 to 3.
// R18: bit 2 set when transmit holding free, cleared on write; bit 7 full.
// R19: bit 1 low while shifting, high when done; resets high.
// R20: bit 0 reads noise seen; write sets noise filter on or off.
// R21: software enables control bit 5 and system mask for interrupts.
// R22: control keeps contents over stop recovery, no reset there.
// R23: control bit 4 enables parity, bit 3 selects odd.
// R24: send-break holds output low; bit 1 selects two stop bits.
module sbt_uart (
    input  wire logic             CLK_I,
    input  wire logic             RESETN_I,
    input  wire sbt_pkg::sbt_wb_req_t WB_REQ_I,
    output logic [7:0]            WB_DAT_O,
    output logic                  WB_ACK_O,
    input  wire logic             STOP_RECOVERY_I,
    input  wire logic             RXD_I,
    output logic                  TXD_O,
    output logic                  RX_IRQ_O,
    output logic                  TX_IRQ_O
);
    import sbt_pkg::*;

    typedef enum {RX_IDLE, RX_START, RX_BITS, RX_PAR, RX_STOP, RX_STOP2} sbt_rx_st_t;
    typedef enum {TX_IDLE, TX_START, TX_BITS, TX_PAR, TX_STOP, TX_STOP2} sbt_tx_st_t;

    logic [7:0] ctrl_q, div_q, irqctl_q, hold_q, thr_q, tsr_q, rsr_q;
    logic       full_q, par_q, ovr_q, frm_q, brk_q, noise_q, filt_q;
    logic       ovr_pend_q, brkov_pend_q, brk_pend_q, ovr_irq_arm_q;
    logic       thr_full_q, txbusy_q, txd_q;
    logic       rx_irq_q, tx_irq_q, ack_q;
    logic       bg_tick, bg_reload;
    logic [7:0] bg_count;
    logic [3:0] rx_os_q, tx_os_q;
    logic [2:0] rx_bit_q, tx_bit_q;
    logic       rx_par_q, tx_par_q, rx_allz_q;
    logic [2:0] rx_hist_q;
    logic       rx_s;
    sbt_rx_st_t rx_st_q;
    sbt_tx_st_t tx_st_q;
    sbt_rx_res_t res;

    logic       wb_hit, wr_en, rd_en, rd_data, wr_data;

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction : majority

    // classic wishbone: one-cycle ack, write and read side effects at ack
    assign wb_hit  = WB_REQ_I.cyc && WB_REQ_I.stb && !ack_q;
    assign wr_en   = wb_hit && WB_REQ_I.we && WB_REQ_I.sel[0];
    assign rd_en   = wb_hit && !WB_REQ_I.we;
    assign rd_data = rd_en && (WB_REQ_I.adr == ADDR_DATA);
    assign wr_data = wr_en && (WB_REQ_I.adr == ADDR_DATA);

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            ack_q    <= 1'b0;
            WB_DAT_O <= 8'h00;
        end else begin
            ack_q <= wb_hit;
            if (rd_en) begin
                case (WB_REQ_I.adr)
                    ADDR_DATA:    WB_DAT_O <= hold_q; // R16
                    ADDR_STATUS:  WB_DAT_O <= {full_q, par_q, ovr_q, frm_q, brk_q,
                                               ctrl_q[CT_TXEN] & !thr_full_q,
                                               !(txbusy_q | thr_full_q), noise_q}; // R18 R19
                    ADDR_CONTROL: WB_DAT_O <= ctrl_q;
                    ADDR_DIVISOR: WB_DAT_O <= ctrl_q[CT_TIMER] ? bg_count : div_q; // R15
                    ADDR_IRQCTL:  WB_DAT_O <= irqctl_q;
                    default:      WB_DAT_O <= 8'h00;
                endcase
            end
        end
    end
    assign WB_ACK_O = ack_q;

    // control register: reset only by RESETN_I, untouched by stop recovery
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            ctrl_q   <= CONTROL_RESET; // R22
            div_q    <= DIVISOR_RESET;
            irqctl_q <= IRQCTL_RESET;
            filt_q   <= 1'b0;
        end else if (wr_en) begin
            case (WB_REQ_I.adr)
                ADDR_CONTROL: ctrl_q   <= WB_REQ_I.dat; // R13
                ADDR_DIVISOR: div_q    <= WB_REQ_I.dat;
                ADDR_IRQCTL:  irqctl_q <= WB_REQ_I.dat;
                ADDR_STATUS:  filt_q   <= WB_REQ_I.dat[ST_NOISE]; // R20
                default:      ;
            endcase
        end
    end

    sbt_baud_gen #(.CNT_W(8)) u_baud (
        .clk_i     (CLK_I),
        .resetn_i  (RESETN_I),
        .divisor_i (div_q),
        .tick_o    (bg_tick),
        .reload_o  (bg_reload),
        .count_o   (bg_count)
    );

    // receive sampler with optional 3-sample majority noise filter
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rx_hist_q <= 3'b111;
        end else begin
            rx_hist_q <= {rx_hist_q[1:0], RXD_I};
        end
    end
    assign rx_s = filt_q ? majority(rx_hist_q) : rx_hist_q[0];

    // receive shifter, 16 baud ticks per bit, sample mid-bit
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rx_st_q   <= RX_IDLE;
            rx_os_q   <= 4'h0;
            rx_bit_q  <= 3'h0;
            rsr_q     <= 8'h00;
            rx_par_q  <= 1'b0;
            rx_allz_q <= 1'b0;
            res       <= '0;
        end else begin
            res.done <= 1'b0;
            if (!ctrl_q[CT_RXEN]) begin
                rx_st_q <= RX_IDLE;
            end else if (bg_tick) begin
                rx_os_q <= rx_os_q + 4'h1;
                case (rx_st_q)
                    RX_IDLE: begin
                        rx_os_q <= 4'h0;
                        if (!rx_s) begin
                            rx_st_q <= RX_START;
                        end
                    end
                    RX_START: if (rx_os_q == 4'h7) begin
                        rx_os_q   <= 4'h0;
                        rx_bit_q  <= 3'h0;
                        rx_par_q  <= ctrl_q[CT_PARODD];
                        rx_allz_q <= 1'b1;
                        res.noise <= rx_hist_q[0] ^ rx_hist_q[1];
                        rx_st_q   <= rx_s ? RX_IDLE : RX_BITS;
                    end
                    RX_BITS: if (rx_os_q == 4'hF) begin
                        rsr_q     <= {rx_s, rsr_q[7:1]};
                        rx_par_q  <= rx_par_q ^ rx_s;
                        rx_allz_q <= rx_allz_q & !rx_s;
                        rx_bit_q  <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7) begin
                            rx_st_q <= ctrl_q[CT_PAREN] ? RX_PAR : RX_STOP; // R23
                        end
                    end
                    RX_PAR: if (rx_os_q == 4'hF) begin
                        res.par_err <= rx_par_q ^ rx_s; // R23
                        rx_allz_q   <= rx_allz_q & !rx_s;
                        rx_st_q     <= RX_STOP;
                    end
                    RX_STOP: if (rx_os_q == 4'hF) begin
                        if (!ctrl_q[CT_PAREN]) begin
                            res.par_err <= 1'b0;
                        end
                        res.frm_err <= !rx_s; // R6
                        res.data    <= rsr_q;
                        rx_allz_q   <= rx_allz_q & !rx_s;
                        if (ctrl_q[CT_STOP2]) begin
                            rx_st_q <= RX_STOP2;
                        end else begin
                            res.brk  <= rx_allz_q & !rx_s; // R2
                            res.done <= 1'b1;
                            rx_st_q  <= RX_IDLE;
                        end
                    end
                    RX_STOP2: if (rx_os_q == 4'hF) begin
                        res.brk  <= rx_allz_q & !rx_s; // R2 R6
                        res.done <= 1'b1;
                        rx_st_q  <= RX_IDLE;
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end

    // holding register and status; new events win over a read clear
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            hold_q        <= 8'h00;
            full_q        <= 1'b0;
            par_q         <= 1'b0;
            ovr_q         <= 1'b0;
            frm_q         <= 1'b0;
            brk_q         <= 1'b0;
            noise_q       <= 1'b0;
            ovr_pend_q    <= 1'b0;
            brkov_pend_q  <= 1'b0;
            brk_pend_q    <= 1'b0;
            ovr_irq_arm_q <= 1'b0;
        end else begin
            if (rd_data) begin
                full_q        <= ovr_pend_q; // R17 R8
                par_q         <= 1'b0; // R17
                frm_q         <= 1'b0;
                ovr_q         <= ovr_pend_q; // R8 R5
                brk_q         <= brkov_pend_q | brk_pend_q; // R8 R3
                ovr_irq_arm_q <= ovr_pend_q; // R5
                ovr_pend_q    <= 1'b0;
                brkov_pend_q  <= 1'b0;
                brk_pend_q    <= 1'b0;
                noise_q       <= 1'b0;
            end
            if (res.done) begin
                if (full_q && !rd_data) begin
                    ovr_pend_q   <= 1'b1; // R4
                    brkov_pend_q <= brkov_pend_q | res.brk; // R8
                end else if (res.brk && full_q) begin
                    brk_pend_q <= 1'b1; // R3
                end else begin
                    hold_q  <= res.data; // R9
                    full_q  <= 1'b1; // R18
                    par_q   <= res.par_err;
                    frm_q   <= res.frm_err; // R7
                    brk_q   <= res.brk; // R3
                    noise_q <= res.noise; // R20
                    ovr_q   <= 1'b0;
                end
            end
        end
    end

    // receiver interrupt: data (maskable), errors, baud reload
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rx_irq_q <= 1'b0;
        end else begin
            rx_irq_q <= ctrl_q[CT_IRQEN] &&
                        ((irqctl_q[0] && full_q && !ovr_q) || // R1
                         brk_q || frm_q || par_q || // R3 R7
                         ovr_irq_arm_q); // R5
        end
    end
    assign RX_IRQ_O = rx_irq_q | (ctrl_q[CT_IRQEN] && ctrl_q[CT_TIMER] && bg_reload); // R10 R14 R21

    // transmit holding and shifter
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            thr_q      <= 8'h00;
            thr_full_q <= 1'b0;
            tsr_q      <= 8'h00;
            txbusy_q   <= 1'b0;
            tx_st_q    <= TX_IDLE;
            tx_os_q    <= 4'h0;
            tx_bit_q   <= 3'h0;
            tx_par_q   <= 1'b0;
            txd_q      <= 1'b1;
        end else begin
            if (wr_data && ctrl_q[CT_TXEN]) begin
                thr_q      <= WB_REQ_I.dat; // R16
                thr_full_q <= 1'b1; // R18
            end
            if (bg_tick) begin
                tx_os_q <= tx_os_q + 4'h1;
                case (tx_st_q)
                    TX_IDLE: begin
                        tx_os_q <= 4'h0;
                        txd_q   <= 1'b1;
                        if (thr_full_q && ctrl_q[CT_TXEN]) begin
                            tsr_q      <= thr_q;
                            thr_full_q <= 1'b0;
                            txbusy_q   <= 1'b1; // R19
                            tx_par_q   <= ctrl_q[CT_PARODD];
                            txd_q      <= 1'b0;
                            tx_st_q    <= TX_START;
                        end else begin
                            txbusy_q <= 1'b0; // R19
                        end
                    end
                    TX_START: if (tx_os_q == 4'hF) begin
                        tx_bit_q <= 3'h0;
                        txd_q    <= tsr_q[0];
                        tx_st_q  <= TX_BITS;
                    end
                    TX_BITS: if (tx_os_q == 4'hF) begin
                        tx_par_q <= tx_par_q ^ tsr_q[0];
                        tsr_q    <= {1'b0, tsr_q[7:1]};
                        tx_bit_q <= tx_bit_q + 3'h1;
                        if (tx_bit_q == 3'h7) begin
                            txd_q   <= ctrl_q[CT_PAREN] ? (tx_par_q ^ tsr_q[0]) : 1'b1;
                            tx_st_q <= ctrl_q[CT_PAREN] ? TX_PAR : TX_STOP;
                        end else begin
                            txd_q <= tsr_q[1];
                        end
                    end
                    TX_PAR: if (tx_os_q == 4'hF) begin
                        txd_q   <= 1'b1;
                        tx_st_q <= TX_STOP;
                    end
                    TX_STOP: if (tx_os_q == 4'hF) begin
                        tx_st_q <= ctrl_q[CT_STOP2] ? TX_STOP2 : TX_IDLE; // R24
                    end
                    TX_STOP2: if (tx_os_q == 4'hF) begin
                        tx_st_q <= TX_IDLE;
                    end
                    default: tx_st_q <= TX_IDLE;
                endcase
            end
        end
    end
    assign TXD_O = ctrl_q[CT_SBRK] ? 1'b0 : txd_q; // R24

    // transmitter interrupt while holding free
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            tx_irq_q <= 1'b0;
        end else begin
            tx_irq_q <= ctrl_q[CT_IRQEN] && ctrl_q[CT_TXEN] && !thr_full_q;
        end
    end
    assign TX_IRQ_O = tx_irq_q;

    logic unused_sr;
    assign unused_sr = STOP_RECOVERY_I; // R22
endmodule : sbt_uart

// >>> verification/sbt_uart_properties.sv
// checker: bus answer timing, read data hold and line and interrupt gating
`timescale 1ns/1ps
module sbt_uart_properties (
    input  wire logic                 CLK_I,
    input  wire logic                 RESETN_I,
    input  wire sbt_pkg::sbt_wb_req_t WB_REQ_I,
    input  wire logic [7:0]           WB_DAT_O,
    input  wire logic                 WB_ACK_O,
    input  wire logic                 TXD_O,
    input  wire logic                 RX_IRQ_O,
    input  wire logic                 TX_IRQ_O
);
    import sbt_pkg::*;
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    logic       take;
    logic       rd_take;
    logic [7:0] ctl_q;

    // request taken at this edge, and its read flavour
    assign take    = WB_REQ_I.cyc && WB_REQ_I.stb && !WB_ACK_O;
    assign rd_take = take && !WB_REQ_I.we;

    // shadow of control, one cycle late, so gating checks skip ack cycles
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            ctl_q <= CONTROL_RESET;
        end else if (WB_ACK_O && WB_REQ_I.we && WB_REQ_I.sel[0]
                     && WB_REQ_I.adr == ADDR_CONTROL) begin
            ctl_q <= WB_REQ_I.dat;
        end
    end

    ack_one_cycle_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    ack_next_edge_a: assert property (take |=> WB_ACK_O)
        else $error("ack missing after request");
    ack_has_cause_a: assert property (WB_ACK_O |-> $past(take))
        else $error("ack without request");
    read_data_hold_a: assert property (!rd_take |=> $stable(WB_DAT_O))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_take && (WB_REQ_I.adr < ADDR_DATA
        || WB_REQ_I.adr > ADDR_IRQCTL) |=> WB_DAT_O == 8'h00)
        else $error("unmapped read not zero");
    break_low_a: assert property (ctl_q[CT_SBRK] && $past(ctl_q[CT_SBRK])
        && !WB_ACK_O |-> !TXD_O)
        else $error("line not low during send break");
    tx_irq_gate_a: assert property (TX_IRQ_O && !WB_ACK_O
        |-> ctl_q[CT_IRQEN] && ctl_q[CT_TXEN])
        else $error("transmit interrupt while disabled");
    rx_irq_gate_a: assert property (RX_IRQ_O && !WB_ACK_O |-> ctl_q[CT_IRQEN])
        else $error("receive interrupt while disabled");
endmodule : sbt_uart_properties

bind sbt_uart sbt_uart_properties u_props (
    .CLK_I    (CLK_I),
    .RESETN_I (RESETN_I),
    .WB_REQ_I (WB_REQ_I),
    .WB_DAT_O (WB_DAT_O),
    .WB_ACK_O (WB_ACK_O),
    .TXD_O    (TXD_O),
    .RX_IRQ_O (RX_IRQ_O),
    .TX_IRQ_O (TX_IRQ_O)
);

// >>> verification/sbt_remote.sv
// far-side serial device: frames toward the receiver, decodes the transmit line
`timescale 1ns/1ps
module sbt_remote #(
    parameter int BIT_CLKS = 256
) (
    input  wire logic  clk_i,
    input  wire logic  txd_i,
    output logic       rxd_o,
    output logic [7:0] got_o
);
    // line rests high between frames
    initial rxd_o = 1'b1;

    // start, data lsb first, optional parity, one stop, one idle bit
    task automatic send(input logic [7:0] b, input logic pe, input logic pb,
                        input logic sb);
        logic [10:0] f;
        f = {sb, pb, b, 1'b0};
        for (int i = 0; i < (pe ? 11 : 10); i++) begin
            rxd_o <= (!pe && i == 9) ? sb : f[i];
            repeat (BIT_CLKS) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask : send

    // sample mid-bit after each start edge on the transmit line
    always begin
        @(negedge txd_i);
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            got_o[i] <= txd_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
    end
endmodule : sbt_remote

// >>> verification/tb_top.sv
// testbench: registers, receive errors, transmit and timer use of the serial block
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin \
        compares++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("BAD %s exp %h got %h", n, e, g); \
        end \
    end
module tb_top;
    import sbt_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        stop_rec = 1'b0;
    sbt_wb_req_t req = '0;
    logic [7:0]  dat;
    logic        ack;
    logic        rxd;
    logic        txd;
    logic        rx_irq;
    logic        tx_irq;
    logic [7:0]  exp_q[$];
    logic [7:0]  msk_q[$];
    logic [7:0]  mon_e;
    logic [7:0]  mon_m;
    logic [7:0]  b;
    logic [7:0]  c;
    int          bad_count = 0;
    int          compares = 0;

    // 40 MHz system clock
    always #12.5 clk = ~clk;

    sbt_uart u_dut (
        .CLK_I           (clk),
        .RESETN_I        (rst_n),
        .WB_REQ_I        (req),
        .WB_DAT_O        (dat),
        .WB_ACK_O        (ack),
        .STOP_RECOVERY_I (stop_rec),
        .RXD_I           (rxd),
        .TXD_O           (txd),
        .RX_IRQ_O        (rx_irq),
        .TX_IRQ_O        (tx_irq)
    );
    sbt_remote u_rem (
        .clk_i (clk),
        .txd_i (txd),
        .rxd_o (rxd),
        .got_o ()
    );

    task automatic results;
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // one classic bus cycle; a read notes its expectation first
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] mk);
        int n;
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(mk);
        end
        req.cyc <= 1'b1;
        req.stb <= 1'b1;
        req.we  <= w;
        req.adr <= a;
        req.sel <= 4'hF;
        req.dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        `CHK("ack", 1'b1, ack)
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (rx_irq !== lvl && n < 8000) begin
            @(posedge clk);
            n++;
        end
        `CHK("rx irq wait", lvl, rx_irq)
    endtask : wait_irq

    // spacing of two reload pulses for one start value
    task automatic gap(input logic [7:0] d, input int exp_n);
        int n;
        wb(1'b1, ADDR_DIVISOR, d, 8'h00);
        wait_irq(1'b1);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rx_irq !== 1'b1 && n < 5000);
        `CHK("timer gap", exp_n, n)
    endtask : gap

    // compare each read answer with the oldest note
    always @(posedge clk) begin
        if (ack === 1'b1 && req.we === 1'b0) begin
            mon_e = exp_q.pop_front();
            mon_m = msk_q.pop_front();
            `CHK("read data", mon_e & mon_m, dat & mon_m)
        end
    end

    // cut a hang short
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        results();
    end

    initial begin
        void'($urandom(60));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset state of lines and registers, unmapped read
        `CHK("txd idle", 1'b1, txd)
        `CHK("rx irq", 1'b0, rx_irq)
        wb(1'b0, ADDR_STATUS, 8'h02, 8'hFF);
        wb(1'b0, ADDR_CONTROL, 8'h00, 8'hFF);
        wb(1'b0, ADDR_DIVISOR, 8'hFF, 8'hFF);
        wb(1'b0, 8'hF0, 8'h00, 8'hFF);
        // control survives a stop-mode recovery
        c = 8'($urandom()) & 8'hFE;
        wb(1'b1, ADDR_CONTROL, c, 8'h00);
        stop_rec <= 1'b1;
        @(posedge clk);
        stop_rec <= 1'b0;
        wb(1'b0, ADDR_CONTROL, c, 8'hFF);
        // one clean character
        wb(1'b1, ADDR_DIVISOR, 8'h01, 8'h00);
        wb(1'b1, ADDR_IRQCTL, 8'h01, 8'h00);
        wb(1'b1, ADDR_CONTROL, 8'hE0, 8'h00);
        // new divisor only takes hold at the reload that ends the reset count
        repeat (4200) @(posedge clk);
        b = 8'($urandom());
        u_rem.send(b, 1'b0, 1'b0, 1'b1);
        wait_irq(1'b1);
        wb(1'b0, ADDR_STATUS, 8'h86, 8'hFF);
        wb(1'b0, ADDR_DATA, b, 8'hFF);
        `CHK("rx irq", 1'b0, rx_irq)
        // second character lands on unread data
        u_rem.send(b, 1'b0, 1'b0, 1'b1);
        u_rem.send(~b, 1'b0, 1'b0, 1'b1);
        wb(1'b0, ADDR_STATUS, 8'h86, 8'hFF);
        wb(1'b0, ADDR_DATA, b, 8'hFF);
        `CHK("overrun irq", 1'b1, rx_irq)
        wb(1'b0, ADDR_STATUS, 8'hA6, 8'hFF);
        wb(1'b0, ADDR_DATA, 8'h00, 8'h00);
        `CHK("overrun irq", 1'b0, rx_irq)
        wb(1'b0, ADDR_STATUS, 8'h06, 8'hFF);
        // low first stop bit, then a break onto an empty holding register
        u_rem.send(b | 8'h01, 1'b0, 1'b0, 1'b0);
        wait_irq(1'b1);
        wb(1'b0, ADDR_STATUS, 8'h10, 8'h10);
        wb(1'b0, ADDR_DATA, 8'h00, 8'h00);
        `CHK("frame irq", 1'b0, rx_irq)
        u_rem.send(8'h00, 1'b0, 1'b0, 1'b0);
        wait_irq(1'b1);
        wb(1'b0, ADDR_STATUS, 8'h08, 8'h08);
        wb(1'b0, ADDR_DATA, 8'h00, 8'h00);
        // even and odd parity, right and wrong, noise filter on
        wb(1'b1, ADDR_STATUS, 8'h01, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wb(1'b1, ADDR_CONTROL, {4'hF, k[0], 3'h0}, 8'h00);
            b = 8'($urandom());
            u_rem.send(b, 1'b1, ^b ^ k[0] ^ k[1], 1'b1);
            wb(1'b0, ADDR_STATUS, {1'b1, k[1], 6'h00}, 8'hC1);
            wb(1'b0, ADDR_DATA, b, 8'hFF);
        end
        // transmit a random byte, then hold the line in break
        `CHK("tx irq", 1'b1, tx_irq)
        wb(1'b1, ADDR_CONTROL, 8'hE0, 8'h00);
        b = 8'($urandom());
        wb(1'b1, ADDR_DATA, b, 8'h00);
        wb(1'b0, ADDR_STATUS, 8'h00, 8'h02);
        repeat (3200) @(posedge clk);
        `CHK("tx byte", b, u_rem.got_o)
        wb(1'b0, ADDR_STATUS, 8'h06, 8'h06);
        wb(1'b1, ADDR_CONTROL, 8'hE4, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("break line", 1'b0, txd)
        // counter as timer: enables cleared first, then timer mode
        wb(1'b1, ADDR_CONTROL, 8'h20, 8'h00);
        wb(1'b1, ADDR_CONTROL, 8'h21, 8'h00);
        gap(8'hC8, 3200);
        repeat (1600) @(posedge clk);
        wb(1'b0, ADDR_DIVISOR, 8'h60, 8'hF0);
        gap(8'h00, 4096);
        results();
    end
endmodule : tb_top
